/* File: core/osd_regs.vh */
`ifndef OSD_REGS_VH
`define OSD_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets (APB, one aligned word each)
// ----------------------------------------------------------------
`define OSD_ADDR_CTRL      12'h000
`define OSD_ADDR_STATUS    12'h004
`define OSD_ADDR_INT_STAT  12'h008
`define OSD_ADDR_INT_MASK  12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OSD_CTRL_EN        0
`define OSD_CTRL_INCH      1
`define OSD_ST_SIZE_LSB    0
`define OSD_ST_EMPTY       4
`define OSD_ST_LID         5
`define OSD_ST_SENS_LSB    6
`define OSD_INT_SIZE       0
`define OSD_INT_LID_ON     1
`define OSD_INT_LID_OFF    2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OSD_CTRL_RST       2'h0
`define OSD_MASK_RST       3'h0
`define OSD_SENS_RST       5'h1F

// ----------------------------------------------------------------
// Size codes reported in STATUS
// ----------------------------------------------------------------
`define OSD_SZ_NONE        4'h0
`define OSD_SZ_A3          4'h1
`define OSD_SZ_A4          4'h2
`define OSD_SZ_B4          4'h3
`define OSD_SZ_B5          4'h4
`define OSD_SZ_A4R         4'h5
`define OSD_SZ_A5          4'h6
`define OSD_SZ_B5R         4'h7
`define OSD_SZ_A5R         4'h8
`define OSD_SZ_LD          4'h9
`define OSD_SZ_LT          4'hA
`define OSD_SZ_LG          4'hB
`define OSD_SZ_LTR         4'hC
`define OSD_SZ_ST          4'hD
`define OSD_SZ_STR         4'hE

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OSD_PCLK_NS        25
`define OSD_EMIT_PERIOD_NS 130000
`define OSD_EMIT_HIGH_NS   8000

`endif

/* File: core/osd_sync.v */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Two-flop synchroniser, one generate lane per bit
// ----------------------------------------------------------------
module osd_sync (
   input  wire       pclk,     // System clock
   input  wire       presetn,  // Async reset, active low
   input  wire [5:0] async_in, // Pin levels from outside
   output wire [5:0] sync_out  // Synchronised levels
);

   genvar i;
   generate
      for (i = 0; i < 6; i = i + 1) begin : g_lane
         reg meta_q;  // First stage, read only by second stage
         reg stab_q;  // Second stage, safe to use
         // Reset to the idle level: receiver dark, lid open
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q <= 1'b0;
               stab_q <= 1'b0;
            end else begin
               meta_q <= async_in[i];
               stab_q <= meta_q;
            end
         end
         assign sync_out[i] = stab_q;
      end
   endgenerate

endmodule

/* File: core/osd_pulse.v */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Emitter pulse timer: period and high time in pclk cycles
// ----------------------------------------------------------------
module osd_pulse #(
   parameter PERIOD_CYC = 5200, // Emitter period in cycles
   parameter HIGH_CYC   = 320   // Emitter high time in cycles
) (
   input  wire pclk,       // System clock
   input  wire presetn,    // Async reset, active low
   input  wire run,        // Timer runs while high
   output reg  emit_q,     // Emitter drive level
   output reg  on_end_q,   // Last cycle of emitter high time
   output reg  per_end_q   // Last cycle of the period
);

   localparam [15:0] LAST_P = PERIOD_CYC[15:0] - 16'h0001;
   localparam [15:0] LAST_H = HIGH_CYC[15:0] - 16'h0001;

   reg [15:0] cnt_q; // Position inside the period

   // ----------------------------------------------------------------
   // Free period counter; stopping it also darkens the emitter
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q     <= 16'h0000;
         emit_q    <= 1'b0;
         on_end_q  <= 1'b0;
         per_end_q <= 1'b0;
      end else if (!run) begin
         cnt_q     <= 16'h0000;
         emit_q    <= 1'b0;
         on_end_q  <= 1'b0;
         per_end_q <= 1'b0;
      end else begin
         cnt_q     <= (cnt_q == LAST_P) ? 16'h0000 : cnt_q + 16'h0001;
         emit_q    <= (cnt_q < LAST_H) || (cnt_q == LAST_P);
         on_end_q  <= (cnt_q == LAST_H - 16'h0001);
         per_end_q <= (cnt_q == LAST_P - 16'h0001);
      end
   end

endmodule

/* File: core/osd_top.v */
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "osd_regs.vh"
// Overview of operation
// R1: Size from all sensor bits, 1 means empty; the inch table ignores p1
// R2: Metric table over centre, right, p1, p2, p3
// R3: Inch table over centre, right, p2, p3
// R4: Lid off and match: report size, select
// R5: Lid off, no match: keep last result
// R6: All ones: report empty, no selection
// R7: Lid off: watch and update on change
// R8: Carriage stays at standby on ratio change
// R9: Lid on: freeze last result, ignore sensors
// R10: Emitter pulse 130 us period, 8 us high
// R11: Original only on matching echo waveform
// R12: Two-flop synchronise every sensor input
module osd_top #(
   parameter EMIT_PERIOD_CYC = `OSD_EMIT_PERIOD_NS / `OSD_PCLK_NS // Period in cycles
) (
   input  wire        pclk,               // APB clock, 40 MHz
   input  wire        presetn,            // Async reset, active low
   input  wire        psel,               // APB select
   input  wire        penable,            // APB access phase
   input  wire        pwrite,             // APB write
   input  wire [11:0] paddr,              // APB byte address
   input  wire [31:0] pwdata,             // APB write data
   output wire [31:0] prdata,             // APB read data
   output wire        pready,             // APB ready
   output wire        pslverr,            // APB error on unmapped address
   input  wire        size_sensor_centre, // Receiver, high while light seen
   input  wire        size_sensor_right,  // Receiver, high while light seen
   input  wire        size_sensor_p1,     // Receiver, high while light seen
   input  wire        size_sensor_p2,     // Receiver, high while light seen
   input  wire        size_sensor_p3,     // Receiver, high while light seen
   input  wire        lid_closed_sensor,  // High while cover is closed
   output wire [4:0]  emitter_drive,      // Infrared emitter drive, all sensors
   output wire [3:0]  size_code,          // Recognised size code
   output wire        glass_empty,        // High when no original
   output wire        select_strobe,      // Pulse: choose paper or ratio
   output wire        carriage_standby,   // Keep carriage 1 at standby
   output wire        irq                 // Level interrupt
);

   // ----------------------------------------------------------------
   // Timing constants
   // ----------------------------------------------------------------
   // High time is a longest figure, so the division rounds down
   localparam EMIT_HIGH_CYC = `OSD_EMIT_HIGH_NS / `OSD_PCLK_NS;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire [5:0]  pins_s;       // Synchronised sensor and lid levels
   wire [4:0]  rx_s;         // Synchronised receivers, centre first
   wire        lid_s;        // Synchronised lid level
   wire        emit;         // Emitter level from the timer
   wire        on_end;       // Sample point for the lit echo
   wire        per_end;      // Sample point for the dark echo
   reg  [1:0]  ctrl_q;       // Enable and series select
   reg  [2:0]  mask_q;       // Interrupt mask
   reg  [2:0]  istat_q;      // Sticky interrupt status
   reg  [2:0]  istat_d;      // Next sticky status
   reg  [31:0] prdata_q;     // Registered read data
   reg         pslverr_q;    // Registered error answer
   reg  [4:0]  lit_q;        // Echo seen during emitter high time
   reg  [4:0]  sens_q;       // Per-point bit, 1 = no original
   reg         sens_vld_q;   // One full period has been judged
   reg  [3:0]  size_q;       // Reported size
   reg         empty_q;      // Reported empty glass
   reg         select_q;     // Selection pulse
   reg         lid_q;        // Lid level one cycle back
   reg  [3:0]  dec_size;     // Decoded size
   reg         dec_hit;      // Pattern is a table size
   reg         dec_empty;    // Pattern is all ones
   wire        setup_ph;     // APB setup cycle
   wire        access_ph;    // APB access cycle
   wire        wr_ctrl;      // Write to control
   wire        wr_mask;      // Write to mask
   wire        rd_istat;     // Read of interrupt status completes
   wire        judge;        // Lid open, block on, new bits ready
   wire        take;         // Accept the decoded result
   wire        ev_size;      // Event: reported result changes
   wire        ev_lid_on;    // Event: cover closed
   wire        ev_lid_off;   // Event: cover opened
   wire        mapped;       // Address hits a register

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Sensor pins are unrelated to pclk; a raw edge could split the
   // pattern across the decoder and report a size never placed
   osd_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({lid_closed_sensor, size_sensor_centre, size_sensor_right,
                  size_sensor_p1, size_sensor_p2, size_sensor_p3}),
      .sync_out (pins_s)
   ); // R12

   assign rx_s  = pins_s[4:0];
   assign lid_s = pins_s[5];

   // ----------------------------------------------------------------
   // Emitter timer
   // ----------------------------------------------------------------
   osd_pulse #(
      .PERIOD_CYC (EMIT_PERIOD_CYC),
      .HIGH_CYC   (EMIT_HIGH_CYC)
   ) u_pulse (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (ctrl_q[`OSD_CTRL_EN]),
      .emit_q    (emit),
      .on_end_q  (on_end),
      .per_end_q (per_end)
   ); // R10

   // Every emitter is driven by the same pulse train
   assign emitter_drive = {5{emit}}; // R10

   // ----------------------------------------------------------------
   // Echo match, one lane per detection point
   // ----------------------------------------------------------------
   // Light counts only when it is high under the pulse and gone in
   // the gap; ambient light is high in both and reads as empty
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_echo
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lit_q[gi]  <= 1'b0;
               sens_q[gi] <= 1'b1;
            end else if (!ctrl_q[`OSD_CTRL_EN]) begin
               // Idle block sees no original
               lit_q[gi]  <= 1'b0;
               sens_q[gi] <= 1'b1;
            end else begin
               if (on_end) begin
                  lit_q[gi] <= rx_s[gi];
               end
               if (per_end) begin
                  sens_q[gi] <= ~(lit_q[gi] & ~rx_s[gi]); // R11 R1
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Judge strobe, in the same cycle the refreshed bits first appear
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sens_vld_q <= 1'b0;
      end else begin
         sens_vld_q <= per_end & ctrl_q[`OSD_CTRL_EN];
      end
   end

   // ----------------------------------------------------------------
   // Size decoder
   // ----------------------------------------------------------------
   // sens_q order: [4] centre, [3] right, [2] p1, [1] p2, [0] p3
   always @* begin
      dec_size  = `OSD_SZ_NONE;
      dec_hit   = 1'b0;
      dec_empty = 1'b0;
      if (!ctrl_q[`OSD_CTRL_INCH]) begin
         dec_hit = 1'b1;
         case (sens_q) // R2 R1
            5'h00: dec_size = `OSD_SZ_A3;   // 00000
            5'h08: dec_size = `OSD_SZ_A4;   // 01000
            5'h02: dec_size = `OSD_SZ_B4;   // 00010
            5'h1A: dec_size = `OSD_SZ_B5;   // 11010
            5'h06: dec_size = `OSD_SZ_A4R;  // 00110
            5'h1E: dec_size = `OSD_SZ_A5;   // 11110
            5'h07: dec_size = `OSD_SZ_B5R;  // 00111
            5'h0F: dec_size = `OSD_SZ_A5R;  // 01111
            5'h1F: begin
               // All points empty
               dec_hit   = 1'b0;
               dec_empty = 1'b1; // R6
            end
            default: begin
               // Not in the table
               dec_hit = 1'b0;
            end
         endcase
      end else begin
         dec_hit = 1'b1;
         // Point p1 is not fitted on inch machines and is ignored
         case ({sens_q[4], sens_q[3], sens_q[1], sens_q[0]}) // R3 R1
            4'h0: dec_size = `OSD_SZ_LD;   // 0000
            4'h4: dec_size = `OSD_SZ_LT;   // 0100
            4'h2: dec_size = `OSD_SZ_LG;   // 0010
            4'h6: dec_size = `OSD_SZ_LTR;  // 0110
            4'hE: dec_size = `OSD_SZ_ST;   // 1110
            4'h7: dec_size = `OSD_SZ_STR;  // 0111
            4'hF: begin
               // All points empty
               dec_hit   = 1'b0;
               dec_empty = 1'b1; // R6
            end
            default: begin
               // Not in the table
               dec_hit = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Result holder
   // ----------------------------------------------------------------
   // Closed lid blocks every update, so the last open-lid result stays
   assign judge = sens_vld_q & ~lid_s; // R9 R7
   // Unmatched patterns never load, so the old result is retained
   assign take  = judge & (dec_hit | dec_empty); // R5
   assign ev_size = take & ((dec_size != size_q) | (dec_empty != empty_q));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_q   <= `OSD_SZ_NONE;
         empty_q  <= 1'b1;
         select_q <= 1'b0;
      end else begin
         select_q <= 1'b0;
         if (take) begin
            size_q  <= dec_size;  // R4 R7
            empty_q <= dec_empty; // R6
            // Only a new real size asks for paper or ratio selection
            if (ev_size & dec_hit) begin
               select_q <= 1'b1; // R4
            end
         end
      end
   end

   assign size_code     = size_q;
   assign glass_empty   = empty_q;
   assign select_strobe = select_q;
   // Ratio changes never move the carriage; hold it while detecting
   assign carriage_standby = ctrl_q[`OSD_CTRL_EN]; // R8

   // ----------------------------------------------------------------
   // Lid edge detect for events
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lid_q <= 1'b0;
      end else begin
         lid_q <= lid_s;
      end
   end

   assign ev_lid_on  = lid_s & ~lid_q;
   assign ev_lid_off = ~lid_s & lid_q;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Zero wait states: every access completes in its first access cycle
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign mapped    = (paddr == `OSD_ADDR_CTRL) | (paddr == `OSD_ADDR_STATUS) |
                      (paddr == `OSD_ADDR_INT_STAT) | (paddr == `OSD_ADDR_INT_MASK);
   assign wr_ctrl   = access_ph & pwrite & (paddr == `OSD_ADDR_CTRL);
   assign wr_mask   = access_ph & pwrite & (paddr == `OSD_ADDR_INT_MASK);
   assign rd_istat  = access_ph & ~pwrite & (paddr == `OSD_ADDR_INT_STAT);

   // ----------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `OSD_CTRL_RST;
         mask_q <= `OSD_MASK_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= pwdata[1:0];
         end
         if (wr_mask) begin
            mask_q <= pwdata[2:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Sticky status, cleared by read
   // ----------------------------------------------------------------
   // Only bits shown in the captured read data are cleared, and a new
   // event in the clearing cycle sets its bit again, so none is lost
   always @* begin
      istat_d = istat_q;
      if (rd_istat) begin
         istat_d = istat_q & ~prdata_q[2:0];
      end
      istat_d = istat_d | {ev_lid_off, ev_lid_on, ev_size};
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_q <= 3'h0;
      end else begin
         istat_q <= istat_d;
      end
   end

   assign irq = |(istat_q & mask_q);

   // ----------------------------------------------------------------
   // Read data, captured in the setup cycle
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (setup_ph) begin
         pslverr_q <= ~mapped;
         prdata_q  <= 32'h00000000;
         if (!pwrite) begin
            case (paddr)
               `OSD_ADDR_CTRL: begin
                  prdata_q[1:0] <= ctrl_q;
               end
               `OSD_ADDR_STATUS: begin
                  prdata_q[3:0]  <= size_q;
                  prdata_q[`OSD_ST_EMPTY] <= empty_q;
                  prdata_q[`OSD_ST_LID]   <= lid_s;
                  prdata_q[10:6] <= sens_q;
               end
               `OSD_ADDR_INT_STAT: begin
                  prdata_q[2:0] <= istat_q;
               end
               `OSD_ADDR_INT_MASK: begin
                  prdata_q[2:0] <= mask_q;
               end
               default: begin
                  // Unmapped reads return zero
                  prdata_q <= 32'h00000000;
               end
            endcase
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = pslverr_q & access_ph;

endmodule

/* File: bench/osd_chk.sv */
`timescale 1ns/10ps
`include "osd_regs.vh"
// ----------------------------------------------------------------
// Port checker for the size detector
// ----------------------------------------------------------------
module osd_chk #(
   parameter EMIT_PERIOD_CYC = 5200 // Emitter period in cycles
) (
   input wire       pclk,              // Clock
   input wire       presetn,           // Reset, active low
   input wire       psel,              // APB select
   input wire       penable,           // APB access phase
   input wire       pslverr,           // APB error
   input wire       lid_closed_sensor, // Cover closed pin
   input wire [4:0] emitter_drive,     // Emitter drive
   input wire [3:0] size_code,         // Reported size
   input wire       glass_empty,       // Empty glass flag
   input wire       select_strobe,     // Selection pulse
   input wire       carriage_standby   // Follows enable
);
   reg  [15:0] gap_q;  // Cycles since last emitter rise
   reg  [9:0]  hi_q;   // Emitter high run length
   reg  [1:0]  seen_q; // Rises seen while running
   wire        rise = emitter_drive[0] && hi_q == 10'h000; // First high cycle
   // Pulse spacing; the first pulse after enable may be short, so it is skipped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q  <= 16'h0000;
         hi_q   <= 10'h000;
         seen_q <= 2'h0;
      end else begin
         gap_q <= rise ? 16'h0000 : gap_q + 16'h0001;
         hi_q  <= emitter_drive[0] ? hi_q + 10'h001 : 10'h000;
         if (!carriage_standby) begin
            seen_q <= 2'h0;
         end else if (rise && seen_q != 2'h2) begin
            seen_q <= seen_q + 2'h1;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   sequence s_lid_held;
      lid_closed_sensor [*5];
   endsequence
   property p_emit_period;
      rise && seen_q == 2'h2 |-> gap_q == EMIT_PERIOD_CYC - 1;
   endproperty
   property p_emit_high;
      !emitter_drive[0] && hi_q != 10'h000 && seen_q == 2'h2 && carriage_standby
         |-> hi_q == 10'h140;
   endproperty
   property p_strobe_one;
      select_strobe |=> !select_strobe;
   endproperty
   property p_strobe_real;
      select_strobe |-> !glass_empty && size_code != `OSD_SZ_NONE;
   endproperty
   property p_empty_none;
      glass_empty |-> size_code == `OSD_SZ_NONE;
   endproperty
   property p_change_cause;
      $changed(size_code) && size_code != `OSD_SZ_NONE |-> select_strobe;
   endproperty
   property p_lid_freeze;
      s_lid_held |=> $stable(size_code) && $stable(glass_empty) && !select_strobe;
   endproperty
   property p_err_access;
      pslverr |-> psel && penable;
   endproperty
   a_emit_period:  assert property (p_emit_period)  else $error("emitter period wrong");
   a_emit_high:    assert property (p_emit_high)    else $error("emitter high time wrong");
   a_strobe_one:   assert property (p_strobe_one)   else $error("select longer than one");
   a_strobe_real:  assert property (p_strobe_real)  else $error("select without size");
   a_empty_none:   assert property (p_empty_none)   else $error("empty with a size");
   a_change_cause: assert property (p_change_cause) else $error("size changed silently");
   a_lid_freeze:   assert property (p_lid_freeze)   else $error("result moved, lid closed");
   a_err_access:   assert property (p_err_access)   else $error("error outside access");
endmodule

/* File: bench/osd_sens.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Photosensor model: paper echoes the emitter pulse
// ----------------------------------------------------------------
module osd_sens (
   input  wire [4:0] emit,    // Emitter drive per point
   input  wire [4:0] pattern, // Points c,r,p1,p2,p3, 1 = no paper
   input  wire       ambient, // Steady stray light on every point
   output wire [4:0] rx       // Receiver levels
);
   // Steady light is not the pulse shape, so it must read as no paper
   assign rx = ambient ? 5'h1F : (~pattern & emit);
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`include "osd_regs.vh"
// ----------------------------------------------------------------
// Testbench: APB tasks and sensor pattern sequences
// ----------------------------------------------------------------
module testbench;
   localparam PER = 400; // Shortened emitter period
   localparam [39:0] MET = {5'h00, 5'h08, 5'h02, 5'h1A, 5'h06, 5'h1E, 5'h07, 5'h0F};
   localparam [23:0] INCH = {4'h0, 4'h4, 4'h2, 4'h6, 4'hE, 4'h7};
   reg         pclk, presetn, psel, penable, pwrite, ambient, lid, err; // Bench drives
   reg  [11:0] paddr;   // APB address
   reg  [31:0] pwdata;  // APB write data
   reg  [31:0] rd;      // Last read data
   reg  [4:0]  pattern; // Wanted sensor bits
   reg  [3:0]  inb;     // Inch table entry
   wire [31:0] prdata;  // APB read data
   wire        pready, pslverr, glass_empty, select_strobe, carriage_standby, irq;
   wire [4:0]  emit, rx; // Emitter and receivers
   wire [3:0]  size_code; // Reported size
   integer     miscompares, checks_done, strobes, i;
   osd_top #(.EMIT_PERIOD_CYC(PER)) u_osd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .size_sensor_centre(rx[4]),
      .size_sensor_right(rx[3]), .size_sensor_p1(rx[2]), .size_sensor_p2(rx[1]),
      .size_sensor_p3(rx[0]), .lid_closed_sensor(lid), .emitter_drive(emit),
      .size_code(size_code), .glass_empty(glass_empty), .select_strobe(select_strobe),
      .carriage_standby(carriage_standby), .irq(irq));
   osd_sens u_osd_sens (.emit(emit), .pattern(pattern), .ambient(ambient), .rx(rx));
   always #12.5 pclk = ~pclk;
   // Count selection pulses for later comparison
   always @(posedge pclk) begin
      if (select_strobe === 1'b1) strobes <= strobes + 1;
   end
   task check(input string what, input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d miscompares %0d", checks_done, miscompares);
         if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // One APB transfer; holds the request until pready is seen high
   task apb(input w, input [11:0] a, input [31:0] d);
      integer k;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         for (k = 0; pready !== 1'b1 && k < 16; k = k + 1) @(posedge pclk);
         if (k == 16) begin
            miscompares = miscompares + 1;
            tally_and_finish;
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rdchk(input [11:0] a, input [31:0] exp, input string what);
      begin
         apb(1'b0, a, 32'h0);
         check(what, rd, exp);
      end
   endtask
   // New pattern, wait past the answer time, compare result and pulse count
   task step(input [4:0] p, input [3:0] code, input integer ns);
      integer n;
      begin
         n = strobes;
         pattern <= p;
         repeat (3 * PER) @(posedge pclk);
         check("size", size_code, code);
         check("empty", glass_empty, code == `OSD_SZ_NONE);
         check("strobes", strobes - n, ns);
      end
   endtask
   initial begin
      {pclk, presetn, psel, penable, pwrite, ambient, lid, paddr, pwdata} = 0;
      {miscompares, checks_done, strobes} = 0;
      pattern = 5'h1F;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(`OSD_ADDR_CTRL, 32'h0, "ctrl");
      rdchk(`OSD_ADDR_STATUS, 32'h7D0, "status");
      rdchk(`OSD_ADDR_INT_STAT, 32'h0, "int_stat");
      rdchk(12'h010, 32'h0, "unmapped");
      check("pslverr", err, 1'b1);
      apb(1'b1, `OSD_ADDR_STATUS, 32'hFFFFFFFF);
      rdchk(`OSD_ADDR_STATUS, 32'h7D0, "status ro");
      apb(1'b1, `OSD_ADDR_INT_MASK, 32'h1);
      rdchk(`OSD_ADDR_INT_MASK, 32'h1, "mask");
      apb(1'b1, `OSD_ADDR_CTRL, 32'h1);
      check("standby", carriage_standby, 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
         step(MET[39-5*i -: 5], `OSD_SZ_A3 + i, 1);
         rdchk(`OSD_ADDR_STATUS, {MET[39-5*i -: 5], 6'h00} | (`OSD_SZ_A3 + i), "st");
      end
      check("irq", irq, 1'b1);
      rdchk(`OSD_ADDR_INT_STAT, 32'h1, "int_stat");
      check("irq clear", irq, 1'b0);
      step(5'h15, `OSD_SZ_A5R, 0);
      step(5'h1F, `OSD_SZ_NONE, 0);
      step(5'h08, `OSD_SZ_A4, 1);
      ambient <= 1'b1;
      step(5'h08, `OSD_SZ_NONE, 0);
      lid <= 1'b1;
      repeat (3 * PER) @(posedge pclk);
      rdchk(`OSD_ADDR_INT_STAT, 32'h3, "lid on");
      ambient <= 1'b0;
      step(5'h00, `OSD_SZ_NONE, 0);
      lid <= 1'b0;
      step(5'h00, `OSD_SZ_A3, 1);
      rdchk(`OSD_ADDR_INT_STAT, 32'h5, "lid off");
      apb(1'b1, `OSD_ADDR_CTRL, 32'h3);
      for (i = 0; i < 6; i = i + 1) begin
         inb = INCH[23-4*i -: 4];
         step({inb[3:2], i[0], inb[1:0]}, `OSD_SZ_LD + i, 1);
      end
      tally_and_finish;
   end
endmodule
bind osd_top osd_chk #(.EMIT_PERIOD_CYC(EMIT_PERIOD_CYC)) u_osd_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
   .lid_closed_sensor(lid_closed_sensor), .emitter_drive(emitter_drive),
   .size_code(size_code), .glass_empty(glass_empty), .select_strobe(select_strobe),
   .carriage_standby(carriage_standby));
